// File: rtl/pmr_result_bank.sv
// Result register bank: latest bus and sense samples, power products and
// 56-bit accumulators per channel, read by the management interface.
// Assumes conversions arrive as one-cycle strobes with ranges held steady.
// What this block does
// - Each active channel keeps a 56-bit accumulator summing power products.
// - An accumulation select makes it sum sense or bus samples instead.
// - The accumulator reads unsigned when both ranges are unipolar, else signed.
// - Power is computed from signed values and shown unsigned only if both unipolar.
// - Power arithmetic keeps all 18 sense bits but only the 14 upper bus bits.
// - The latest bus sample of each channel is held in a 16-bit register.
// - The latest sense sample of each channel is held in a 16-bit register.
// - One register per channel, accumulators, bus then sense at consecutive addresses.
// - A per-channel count grows each time a value is summed.
// - Power is bits 33:4 of the 14 upper bus bits times the sense value.
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.svh"
module pmr_result_bank (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // Conversion results, one strobe per sample
  input  wire logic                    conv_valid,
  input  wire logic [1:0]              conv_ch,
  input  wire logic [17:0]             conv_bus_raw,
  input  wire logic [17:0]             conv_sense_raw,
  // Configuration
  input  wire logic [3:0]              ch_active,
  input  wire logic [3:0]              bus_bipolar,
  input  wire logic [3:0]              sense_bipolar,
  input  wire logic [3:0][1:0]         acc_select,
  // Register read and write port
  input  wire logic                    reg_rd,
  input  wire logic                    reg_wr,
  input  wire logic [`PMR_ADDR_W-1:0]  reg_addr,
  input  wire logic [`PMR_ACC_W-1:0]   reg_wdata,
  output logic      [`PMR_ACC_W-1:0]   reg_rdata,
  output logic                         reg_hit,
  // Accumulation counts and power products
  output logic [3:0][`PMR_CNT_W-1:0]   accumulation_count,
  output logic [3:0][`PMR_PWR_W-1:0]   power_product
);
  pmr_pkg::pmr_state_t st;
  pmr_pkg::pmr_state_t next_st;

  // Raw samples carry two extra fraction bits; only the sense ones are kept through the product
  function automatic logic [`PMR_RES_W-1:0] report(input logic [17:0] raw);
    report = raw[17:2];
  endfunction

  // Index within a block of four consecutive registers
  function automatic logic in_block(input logic [7:0] a, input logic [7:0] b);
    in_block = (a >= b) && (a < b + 8'h04);
  endfunction

  logic                      bip;
  logic signed [15:0]        bus_top;
  // One spare bit so a unipolar 18-bit sense sample keeps every bit
  logic signed [18:0]        sense_s;
  logic signed [34:0]        prod_s;
  logic [`PMR_PWR_W-1:0]     prod_r;
  logic [`PMR_ACC_W-1:0]     addend;
  logic [1:0]                idx;

  always_comb begin
    next_st = st;
    bip = bus_bipolar[conv_ch] | sense_bipolar[conv_ch];
    // Signed math on both operands, extra sense bits kept
    bus_top = $signed({2'b00, conv_bus_raw[17:4]});
    if (bus_bipolar[conv_ch]) begin
      bus_top = $signed({conv_bus_raw[17], conv_bus_raw[17:4], 1'b0}) >>> 1;
    end
    sense_s = sense_bipolar[conv_ch]
              ? $signed({conv_sense_raw[17], conv_sense_raw})
              : $signed({1'b0, conv_sense_raw});
    prod_s = bus_top * sense_s;
    prod_r = prod_s[33:4];
    if (!bip && prod_s[34]) begin
      prod_r = '0;
    end
    addend = bip ? {{26{prod_r[29]}}, prod_r} : {26'h0, prod_r};
    case (acc_select[conv_ch])
      2'b10: addend = bip ? {{40{conv_sense_raw[17]}}, report(conv_sense_raw)}
                          : {40'h0, report(conv_sense_raw)};
      2'b11: addend = bip ? {{40{conv_bus_raw[17]}}, report(conv_bus_raw)}
                          : {40'h0, report(conv_bus_raw)};
      default: ;
    endcase
    if (conv_valid && ch_active[conv_ch]) begin
      next_st.bus[conv_ch]   = report(conv_bus_raw);
      next_st.sense[conv_ch] = report(conv_sense_raw);
      next_st.power[conv_ch] = prod_r;
      next_st.acc[conv_ch]   = st.acc[conv_ch] + addend;
      next_st.count[conv_ch] = st.count[conv_ch] + 32'h0000_0001;
    end
    // Writes never touch the results
    next_st.rdata = '0;
    idx = reg_addr[1:0] + 2'b01;
    if (in_block(reg_addr, `PMR_OFF_ACC)) begin
      next_st.rdata = st.acc[idx];
    end else if (in_block(reg_addr, `PMR_OFF_BUS)) begin
      next_st.rdata = {40'h0, st.bus[reg_addr[1:0] + 2'b01]};
    end else if (in_block(reg_addr, `PMR_OFF_SENSE)) begin
      next_st.rdata = {40'h0, st.sense[reg_addr[1:0] + 2'b01]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata          = st.rdata;
  assign reg_hit            = reg_rd && (reg_addr >= `PMR_OFF_ACC)
                              && (reg_addr < `PMR_OFF_END);
  assign accumulation_count = st.count;
  assign power_product      = st.power;

  a_acc_sums: assert property (@(posedge ref_clk) disable iff (rst)
    conv_valid && ch_active[conv_ch] |=> st.acc[$past(conv_ch)]
      == $past(st.acc[conv_ch]) + $past(addend))
    else $error("accumulator did not sum");
  a_count_step: assert property (@(posedge ref_clk) disable iff (rst)
    conv_valid && ch_active[conv_ch] |=> st.count[$past(conv_ch)]
      == $past(st.count[conv_ch]) + 32'h0000_0001)
    else $error("count did not step");
  a_bus_hold: assert property (@(posedge ref_clk) disable iff (rst)
    conv_valid && ch_active[conv_ch] |=>
      st.bus[$past(conv_ch)] == $past(conv_bus_raw[17:2]))
    else $error("bus result wrong");
  a_sense_hold: assert property (@(posedge ref_clk) disable iff (rst)
    conv_valid && ch_active[conv_ch] |=>
      st.sense[$past(conv_ch)] == $past(conv_sense_raw[17:2]))
    else $error("sense result wrong");
  a_idle_keep: assert property (@(posedge ref_clk) disable iff (rst)
    !conv_valid |=> $stable(st.acc) && $stable(st.bus))
    else $error("results moved without sample");
  a_sel_sense: assert property (@(posedge ref_clk) disable iff (rst)
    conv_valid && ch_active[conv_ch] && acc_select[conv_ch] == 2'b10
      && !bip |-> addend == {40'h0, conv_sense_raw[17:2]})
    else $error("sense select wrong");
  a_unsigned_pwr: assert property (@(posedge ref_clk) disable iff (rst)
    !bip && conv_valid |-> addend[55:30] == 26'h0)
    else $error("unipolar addend signed");
  a_bus_read: assert property (@(posedge ref_clk) disable iff (rst)
    reg_addr == `PMR_OFF_BUS |=> reg_rdata == {40'h0, $past(st.bus[0])})
    else $error("bus read map wrong");

  // A conversion that the bank actually takes
  sequence s_conv_taken;
    conv_valid && ch_active[conv_ch];
  endsequence

  // A conversion for a channel that is switched off
  sequence s_conv_dropped;
    conv_valid && !ch_active[conv_ch];
  endsequence

  // Sample selects pick the reported bits, not the raw ones
  a_sel_bus: assert property (@(posedge ref_clk) disable iff (rst)
    conv_valid && ch_active[conv_ch] && acc_select[conv_ch] == 2'b11
      && !bip |-> addend == {40'h0, conv_bus_raw[17:2]})
    else $error("bus select wrong");

  a_power_reg: assert property (@(posedge ref_clk) disable iff (rst)
    s_conv_taken |=> st.power[$past(conv_ch)] == $past(prod_r))
    else $error("power product not stored");

  // Negative unipolar products would wrap into huge energies
  a_pwr_clamp: assert property (@(posedge ref_clk) disable iff (rst)
    !bip && prod_s[34] |-> prod_r == 30'h0)
    else $error("unipolar power not clamped");

  a_bip_extend: assert property (@(posedge ref_clk) disable iff (rst)
    conv_valid && bip && acc_select[conv_ch] < 2'b10
      |-> addend[55:29] == {27{prod_r[29]}})
    else $error("bipolar addend not extended");

  a_idle_count: assert property (@(posedge ref_clk) disable iff (rst)
    !conv_valid |=> $stable(st.count) && $stable(st.sense))
    else $error("count or sense moved without sample");

  a_inactive_drop: assert property (@(posedge ref_clk) disable iff (rst)
    s_conv_dropped |=> $stable(st.acc) && $stable(st.count))
    else $error("inactive channel summed");

  // Writes have no path into the state at all
  a_write_inert: assert property (@(posedge ref_clk) disable iff (rst)
    reg_wr && !conv_valid |=> $stable(st.acc) && $stable(st.bus)
      && $stable(st.sense))
    else $error("write changed a result");

  a_acc_read: assert property (@(posedge ref_clk) disable iff (rst)
    reg_addr == `PMR_OFF_ACC |=> reg_rdata == $past(st.acc[0]))
    else $error("accumulator read map wrong");

  a_sense_read: assert property (@(posedge ref_clk) disable iff (rst)
    reg_addr == `PMR_OFF_SENSE
      |=> reg_rdata == {40'h0, $past(st.sense[0])})
    else $error("sense read map wrong");

  a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (rst)
    reg_addr >= `PMR_OFF_END |=> reg_rdata == 56'h00_0000_0000_0000)
    else $error("unmapped address read nonzero");

  a_bus_narrow: assert property (@(posedge ref_clk) disable iff (rst)
    in_block(reg_addr, `PMR_OFF_BUS) |=> reg_rdata[55:16] == 40'h0)
    else $error("bus read has high bits");

  a_hit_range: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == `PMR_OFF_ACC |-> reg_hit)
    else $error("mapped read not flagged");
endmodule
`default_nettype wire

// File: inc/pmr_consts.svh
// Constants for the power monitor result register bank.
// Assumes inclusion by bare name from the package and the design.
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH
`define PMR_NUM_CH       3'd4
`define PMR_ADDR_W       8
`define PMR_ACC_W        56
`define PMR_RES_W        16
`define PMR_PWR_W        30
`define PMR_CNT_W        32
`define PMR_BUS_MSB_W    14
`define PMR_OFF_ACC      8'h03
`define PMR_OFF_BUS      8'h07
`define PMR_OFF_SENSE    8'h0b
`define PMR_OFF_END      8'h0f
`define PMR_RESET_VAL    56'h00_0000_0000_0000
`endif

// File: inc/pmr_pkg.sv
// Types for the power monitor result register bank.
// Assumes pmr_consts.svh is on the include path.
`include "pmr_consts.svh"
package pmr_pkg;
  typedef enum logic [1:0] {
    PMR_SEL_POWER = 2'b01,
    PMR_SEL_SENSE = 2'b10,
    PMR_SEL_BUS   = 2'b11
  } pmr_sel_t;
  typedef logic [`PMR_ACC_W-1:0] pmr_acc_t;
  typedef logic [`PMR_RES_W-1:0] pmr_res_t;
  typedef struct packed {
    pmr_acc_t [3:0]              acc;
    pmr_res_t [3:0]              bus;
    pmr_res_t [3:0]              sense;
    logic [3:0][`PMR_PWR_W-1:0]  power;
    logic [3:0][`PMR_CNT_W-1:0]  count;
    logic [`PMR_ACC_W-1:0]       rdata;
  } pmr_state_t;
endpackage

// File: dv/pmr_host_model.sv
// Host model: reads and writes the result registers over the register port.
// Assumes requests start on a falling edge and answers come one edge later.
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.svh"
module pmr_host_model (
  // Clock
  input  wire logic                  ref_clk,
  // Register port
  output logic                       reg_rd,
  output logic                       reg_wr,
  output logic [`PMR_ADDR_W-1:0]     reg_addr,
  output logic [`PMR_ACC_W-1:0]      reg_wdata,
  input  wire logic [`PMR_ACC_W-1:0] reg_rdata
);
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 56'h00_0000_0000_0000;
  end
  task automatic xfer(input logic wr, input logic [7:0] a,
                      output logic [55:0] d);
    @(negedge ref_clk);
    reg_rd = !wr;
    reg_wr = wr;
    reg_addr = a;
    reg_wdata = 56'hff_ffff_ffff_ffff;
    @(negedge ref_clk);
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    // Released address must not look like the last one
    reg_addr = ~a;
  endtask
endmodule
`default_nettype wire

// File: dv/power_monitor_result_registers_bench.sv
// Bench for the result bank: conversions driven here, registers via host.
// Assumes a 100 MHz clock and inputs changed on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module power_monitor_result_registers_bench;
  logic ref_clk, rst, conv_valid, reg_rd, reg_wr, reg_hit;
  logic [1:0] conv_ch;
  logic [17:0] conv_bus_raw, conv_sense_raw;
  logic [3:0] ch_active, bus_bipolar, sense_bipolar;
  logic [3:0][1:0] acc_select;
  logic [7:0] reg_addr;
  logic [55:0] reg_wdata, reg_rdata, d;
  logic [3:0][31:0] accumulation_count;
  logic [3:0][29:0] power_product;
  int fails, check_count, cycles;
  pmr_result_bank dut (.ref_clk(ref_clk), .rst(rst), .conv_valid(conv_valid),
    .conv_ch(conv_ch), .conv_bus_raw(conv_bus_raw),
    .conv_sense_raw(conv_sense_raw), .ch_active(ch_active),
    .bus_bipolar(bus_bipolar), .sense_bipolar(sense_bipolar),
    .acc_select(acc_select), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .accumulation_count(accumulation_count),
    .power_product(power_product));
  pmr_host_model host (.ref_clk(ref_clk), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic print_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [55:0] seen, input logic [55:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [55:0] exp);
    fork
      host.xfer(1'b0, a, d);
      begin
        @(negedge ref_clk);
        #1;
        check({55'h0, reg_hit}, {55'h0, (a >= 8'h03) && (a < 8'h0f)});
      end
    join
    check(d, exp);
  endtask
  task automatic conv(input logic [1:0] ch, input logic [17:0] b, s);
    @(negedge ref_clk);
    conv_valid = 1'b1;
    conv_ch = ch;
    conv_bus_raw = b;
    conv_sense_raw = s;
    @(negedge ref_clk);
    conv_valid = 1'b0;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard, far above the roughly 45 cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    rst = 1'b1;
    {conv_valid, conv_ch, conv_bus_raw, conv_sense_raw} = 39'h0;
    {ch_active, bus_bipolar, sense_bipolar, acc_select} = 20'h3_0000;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    rd(8'h03, 56'h0);
    rd(8'h07, 56'h0);
    rd(8'h0b, 56'h0);
    repeat (2) conv(2'd0, 18'h0_4000, 18'h0_0100);
    rd(8'h03, 56'h8000);
    check(power_product[0], 56'h4000);
    check(accumulation_count[0], 56'h2);
    rd(8'h07, 56'h1000);
    rd(8'h0b, 56'h0040);
    host.xfer(1'b1, 8'h07, d);
    rd(8'h07, 56'h1000);
    // Channel two is inactive, so its conversion is dropped
    conv(2'd2, 18'h0_4000, 18'h0_0100);
    rd(8'h09, 56'h0);
    rd(8'h0f, 56'h0);
    bus_bipolar = 4'b0010;
    conv(2'd1, 18'h3_fff0, 18'h0_0100);
    check(power_product[1], 56'h3fff_fff0);
    rd(8'h04, 56'hff_ffff_ffff_fff0);
    rd(8'h08, 56'hfffc);
    rd(8'h0c, 56'h0040);
    acc_select[0] = 2'b10;
    conv(2'd0, 18'h0_4000, 18'h0_0100);
    rd(8'h03, 56'h8040);
    acc_select[0] = 2'b11;
    conv(2'd0, 18'h0_4000, 18'h0_0100);
    rd(8'h03, 56'h9040);
    print_verdict();
  end
endmodule
`default_nettype wire
